/* logic/gfx_bus_params.svh */
/*
  Constants of the graphics board bus decode: port addresses, field positions,
  mode codes and reset values. Assumes inclusion by the decode module only.
*/
// ----------------------------------------------------------------------------
// Overview of operation
// - Mode port is eight bits: protect, internal/external, alpha/semi, alpha/graphic, color, mode.
// - Mode port loads only on output cycles matching the port address switches.
// - Mode codes: 00 alpha, 20 semi-4, 60 semi-6, 10..17 graphics 0..7.
// - Bit 3 set selects alternate color set or border; clear selects default.
// - With protect jumper fitted the board is disabled unless mode bit 7 is 1.
// - Refresh memory holds 6144 bytes inside an 8K window on any 8K boundary.
// - Window is selected when address bits 15..13 equal the base switches.
// - Wait jumper fitted adds exactly one wait state to each memory cycle.
// - Indicator lights while addressed and enabled, and whenever bank enabled.
// - Bank latch loads on output cycles to fixed port 40 hex.
// - Bank enabled if any 1 data bit has its match switch closed.
// - Power-on clear always clears bank latch; jumpers add external or preset.
// - First memory switch position closed forces the board always bank-enabled.
// - Processor reaches memory only if field sync or row start is low in the idle cycle; the wait-jumper extra cycle grants without recheck.
// - Memory access during active display holds the bus in wait states.
// - Mode port latches data bus on output strobe with low address match.
// ----------------------------------------------------------------------------
`ifndef GFX_BUS_PARAMS_SVH
`define GFX_BUS_PARAMS_SVH

`define BANK_PORT_ADDR    8'h40
`define MODE_RESET        8'h00
`define MEM_BYTES         6144
`define MEM_LAST          13'h17FF
`define BIT_PROTECT       7
`define BIT_INTERNAL_EXTERNAL_SELECT       6
`define BIT_ALPHA_SEMI    5
`define BIT_ALPHA_GRAPHIC 4
`define BIT_COLOR_SET     3
`define BIT_GRAPHIC_MODE2 2
`define BIT_GRAPHIC_MODE1 1
`define BIT_GRAPHIC_MODE0 0
`define MODE_ALPHA        8'h00
`define MODE_SEMI4        8'h20
`define MODE_SEMI6        8'h60
`define MODE_GRAPHIC0     8'h10
`define MODE_ALT_COLOR    8'h08

`endif

/* logic/gfx_bus_pkg.sv */
/*
  Types of the graphics board bus decode. Assumes nothing of its surroundings.
*/
package gfx_bus_pkg;

  typedef enum logic [2:0] {
    MEM_IDLE  = 3'b001,
    MEM_EXTRA = 3'b010,
    MEM_GRANT = 3'b100
  } mem_state_t;

endpackage

/* logic/port_match.sv */
/*
  Equality comparator of an address field against a switch or fixed setting.
  Assumes both operands are synchronous to the same clock.
*/
`timescale 1ns/100ps
module port_match #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] setting,
  input  wire logic         strobe,
  output logic              hit
);

  assign hit = strobe && (value == setting);

endmodule

/* logic/graphics_board_bus_decode.sv */
/*
  Bus-side decode of the colour graphics board: mode port, bank latch and
  the shared refresh memory with its wait-state control. Assumes all bus
  strobes are levels held for the whole bus cycle and synchronous to clk_sys.
*/
`timescale 1ns/100ps
`include "gfx_bus_params.svh"
module graphics_board_bus_decode
  import gfx_bus_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  data_out_bus,
  output logic      [7:0]  data_in_bus,
  output logic             data_in_oe_n,
  input  wire logic        sout,
  input  wire logic        sinp,
  input  wire logic        smemr,
  input  wire logic        mwrt,
  output logic             rdy,
  input  wire logic        power_on_clear,
  input  wire logic        external_clear,
  input  wire logic        preset,
  input  wire logic [7:0]  port_address_switches,
  input  wire logic [7:0]  bank_match_switches,
  input  wire logic [2:0]  memory_base_switches,
  input  wire logic        bank_override_switch,
  input  wire logic        wait_jumper,
  input  wire logic        protect_jumper,
  input  wire logic        external_clear_jumper,
  input  wire logic        bus_preset_clear_jumper,
  input  wire logic        field_sync,
  input  wire logic        row_start_pulse,
  input  wire logic [12:0] video_addr,
  output logic      [7:0]  video_data,
  output logic             board_protect,
  output logic             internal_external_select,
  output logic             alpha_semigraphic_select,
  output logic             alpha_graphic_select,
  output logic             color_set_select,
  output logic             graphic_mode_bit2,
  output logic             graphic_mode_bit1,
  output logic             graphic_mode_bit0,
  output logic             enabled_indicator
);

  logic [7:0]  mode_r;
  logic        bank_r;
  logic [7:0]  mem [0:`MEM_BYTES-1];
  mem_state_t  state_r;
  mem_state_t  state_nxt;
  logic        mode_hit;
  logic        bank_hit;
  logic        base_hit;
  logic        bank_clear;
  logic        bank_en;
  logic        board_en;
  logic        mem_sel;
  logic        mem_req;
  logic        disp_idle;
  logic        grant_now;

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  port_match #(.W(8)) u_mode_match (
    .value   (addr[7:0]),
    .setting (port_address_switches),
    .strobe  (sout),
    .hit     (mode_hit)
  );

  port_match #(.W(8)) u_bank_match (
    .value   (addr[7:0]),
    .setting (`BANK_PORT_ADDR),
    .strobe  (sout),
    .hit     (bank_hit)
  );

  port_match #(.W(3)) u_base_match (
    .value   (addr[15:13]),
    .setting (memory_base_switches),
    .strobe  (smemr || mwrt),
    .hit     (base_hit)
  );

  // Only the low 6K of the 8K window is populated.
  assign mem_sel   = base_hit && (addr[12:0] <= `MEM_LAST);
  assign bank_en   = bank_r || bank_override_switch;
  assign board_en  = bank_en && (!protect_jumper || mode_r[`BIT_PROTECT]);
  assign mem_req   = mem_sel && board_en;
  // Display generator is idle while either timing line is low.
  assign disp_idle = !field_sync || !row_start_pulse;

  // ----------------------------------------------------------------------------
  // Mode port
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_r <= `MODE_RESET;
    end else if (mode_hit) begin
      mode_r <= data_out_bus;
    end
  end

  // Field order of the port drives the display generator directly.
  assign board_protect            = mode_r[`BIT_PROTECT];
  assign internal_external_select = mode_r[`BIT_INTERNAL_EXTERNAL_SELECT];
  assign alpha_semigraphic_select = mode_r[`BIT_ALPHA_SEMI];
  assign alpha_graphic_select     = mode_r[`BIT_ALPHA_GRAPHIC];
  assign color_set_select         = mode_r[`BIT_COLOR_SET];
  assign graphic_mode_bit2        = mode_r[`BIT_GRAPHIC_MODE2];
  assign graphic_mode_bit1        = mode_r[`BIT_GRAPHIC_MODE1];
  assign graphic_mode_bit0        = mode_r[`BIT_GRAPHIC_MODE0];

  // ----------------------------------------------------------------------------
  // Bank latch
  // ----------------------------------------------------------------------------
  assign bank_clear = power_on_clear || (external_clear_jumper && external_clear) ||
                      (bus_preset_clear_jumper && preset);

  always_ff @(posedge clk_sys) begin
    if (srst || bank_clear) begin
      bank_r <= 1'b0;
    end else if (bank_hit) begin
      bank_r <= |(data_out_bus & bank_match_switches);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enabled_indicator <= 1'b0;
    end else begin
      enabled_indicator <= (mem_sel && board_en) || bank_en;
    end
  end

  // ----------------------------------------------------------------------------
  // Memory access sequencing
  // ----------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      MEM_IDLE: begin
        if (mem_req && disp_idle) begin
          state_nxt = wait_jumper ? MEM_EXTRA : MEM_GRANT;
        end
      end
      MEM_EXTRA: begin
        state_nxt = mem_req ? MEM_GRANT : MEM_IDLE;
      end
      MEM_GRANT: begin
        if (!mem_req) begin
          state_nxt = MEM_IDLE;
        end
      end
      default: begin
        state_nxt = MEM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= MEM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign grant_now = mem_req && (state_r != MEM_GRANT) && (state_nxt == MEM_GRANT);
  // Bus is held until the grant, so an active display stretches the cycle.
  assign rdy = !(mem_req && state_r != MEM_GRANT);

  always_ff @(posedge clk_sys) begin
    if (grant_now && mwrt) begin
      mem[addr[12:0]] <= data_out_bus;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_in_bus <= 8'h00;
    end else if (grant_now && smemr) begin
      data_in_bus <= mem[addr[12:0]];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      video_data <= 8'h00;
    end else if (video_addr <= `MEM_LAST) begin
      video_data <= mem[video_addr];
    end
  end

  // Both ports are write-only; only a granted memory read drives the bus.
  assign data_in_oe_n = !(smemr && mem_req && state_r == MEM_GRANT);

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence s_start;
    state_r == MEM_IDLE && mem_req && disp_idle;
  endsequence

  sequence s_held;
    mem_req [*2];
  endsequence

  chk_mode_load: assert property (@(posedge clk_sys) disable iff (srst)
    mode_hit |=> mode_r == $past(data_out_bus))
    else $error("Mode port did not take the bus data.");

  chk_bank_load: assert property (@(posedge clk_sys) disable iff (srst)
    bank_hit && !bank_clear |=> bank_r == |($past(data_out_bus) & $past(bank_match_switches)))
    else $error("Bank latch took the wrong value.");

  chk_bank_clear: assert property (@(posedge clk_sys) disable iff (srst)
    power_on_clear |=> !bank_r)
    else $error("Power-on clear left the bank enabled.");

  chk_one_wait: assert property (@(posedge clk_sys) disable iff (srst)
    s_start ##0 wait_jumper ##0 s_held |-> !rdy ##1 rdy)
    else $error("Wait jumper cycle did not hold exactly one extra wait.");

  chk_no_wait: assert property (@(posedge clk_sys) disable iff (srst)
    s_start ##0 !wait_jumper ##1 mem_req |-> rdy)
    else $error("Memory cycle without jumper waited too long.");

  chk_disp_busy: assert property (@(posedge clk_sys) disable iff (srst)
    state_r == MEM_IDLE && mem_req && !disp_idle |-> !rdy ##1 state_r != MEM_GRANT)
    else $error("Memory granted during active display.");

  chk_protect_gate: assert property (@(posedge clk_sys) disable iff (srst)
    protect_jumper && !mode_r[`BIT_PROTECT] |-> rdy && data_in_oe_n)
    else $error("Protected board answered a memory cycle.");

  chk_port_silent: assert property (@(posedge clk_sys) disable iff (srst)
    sinp && !smemr |-> data_in_oe_n)
    else $error("Data bus driven on an input cycle.");

  chk_indicator: assert property (@(posedge clk_sys) disable iff (srst)
    bank_en |=> enabled_indicator)
    else $error("Indicator dark while bank enabled.");

  chk_window: assert property (@(posedge clk_sys) disable iff (srst)
    !data_in_oe_n |-> addr[15:13] == memory_base_switches && addr[12:0] <= `MEM_LAST)
    else $error("Memory answered outside its window.");

endmodule

/* tb/host_model.sv */
/*
  Host processor model: output, input and memory bus cycles.
  Assumes the decode answers with rdy and data_in_oe_n on clk_sys.
*/
`timescale 1ns/100ps
module host_model (
  input  wire logic        clk_sys,
  input  wire logic        rdy,
  input  wire logic [7:0]  data_in_bus,
  input  wire logic        data_in_oe_n,
  output logic      [15:0] addr,
  output logic      [7:0]  data_out_bus,
  output logic             sout,
  output logic             sinp,
  output logic             smemr,
  output logic             mwrt
);
  initial begin
    {sout, sinp, smemr, mwrt} = 4'h0;
    addr = 16'h0000;
    data_out_bus = 8'h00;
  end
  // Released address and data lines show the inverse of their last value; strobes return to 0.
  task automatic io(input logic o, input logic [7:0] a, d, output logic oe);
    @(negedge clk_sys);
    addr = {8'h00, a};
    data_out_bus = d;
    sout = o;
    sinp = !o;
    #1 oe = data_in_oe_n;
    @(negedge clk_sys);
    oe = oe & data_in_oe_n;
    {sout, sinp} = 2'b00;
    addr = ~addr;
    data_out_bus = ~d;
  endtask
  task automatic mem(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic oe, output int w);
    @(negedge clk_sys);
    addr = a;
    data_out_bus = d;
    smemr = !wr;
    mwrt = wr;
    w = 0;
    #1;
    while (rdy !== 1'b1 && w < 60) begin
      w++;
      @(negedge clk_sys);
      #1;
    end
    q = data_in_bus;
    oe = data_in_oe_n;
    @(negedge clk_sys);
    {smemr, mwrt} = 2'b00;
    addr = ~a;
    data_out_bus = ~d;
  endtask
endmodule

/* tb/graphics_board_bus_decode_test.sv */
/*
  Self-checking bench of the bus decode: mode port, bank latch, memory.
  Assumes host_model drives the bus strobes; the bench drives the rest.
*/
`timescale 1ns/100ps
module graphics_board_bus_decode_test;
  logic        clk_sys = 1'b0, srst = 1'b1, oe;
  logic [15:0] addr;
  logic [7:0]  data_out_bus, data_in_bus, video_data, q, m;
  wire  [7:0]  mode_q;
  logic [7:0]  port_address_switches, bank_match_switches;
  logic [2:0]  memory_base_switches;
  logic [12:0] video_addr;
  logic        data_in_oe_n, sout, sinp, smemr, mwrt, rdy, enabled_indicator;
  logic        power_on_clear, external_clear, preset, bank_override_switch;
  logic        wait_jumper, protect_jumper, external_clear_jumper, bus_preset_clear_jumper;
  logic        field_sync, row_start_pulse;
  int          err_count = 0, check_count = 0, cyc = 0, w, i;
  graphics_board_bus_decode u_graphics_board_bus_decode (
    .clk_sys, .srst, .addr, .data_out_bus, .data_in_bus, .data_in_oe_n, .sout,
    .sinp, .smemr, .mwrt, .rdy, .power_on_clear, .external_clear, .preset,
    .port_address_switches, .bank_match_switches, .memory_base_switches,
    .bank_override_switch, .wait_jumper, .protect_jumper, .external_clear_jumper,
    .bus_preset_clear_jumper, .field_sync, .row_start_pulse, .video_addr,
    .video_data, .board_protect(mode_q[7]), .internal_external_select(mode_q[6]),
    .alpha_semigraphic_select(mode_q[5]), .alpha_graphic_select(mode_q[4]),
    .color_set_select(mode_q[3]), .graphic_mode_bit2(mode_q[2]),
    .graphic_mode_bit1(mode_q[1]), .graphic_mode_bit0(mode_q[0]), .enabled_indicator
  );
  host_model u_host_model (
    .clk_sys, .rdy, .data_in_bus, .data_in_oe_n, .addr, .data_out_bus, .sout,
    .sinp, .smemr, .mwrt
  );
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic check(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {power_on_clear, external_clear, preset, bank_override_switch} = 4'h0;
    {wait_jumper, protect_jumper, external_clear_jumper, bus_preset_clear_jumper} = 4'h0;
    {field_sync, row_start_pulse} = 2'b00;
    video_addr = 13'h0000;
    port_address_switches = 8'h5A;
    bank_match_switches = 8'h12;
    memory_base_switches = 3'h6;
    step(12);
    srst = 1'b0;
    step(1);
    check(mode_q, 8'h00);
    u_host_model.io(1'b1, 8'h5A, 8'h9F, oe);
    check(mode_q, 8'h9F);
    u_host_model.io(1'b1, 8'h5B, 8'h00, oe);
    check(mode_q, 8'h9F);
    for (i = 0; i < 22; i++) begin
      m = (i < 2) ? 8'h00 : (i < 4) ? 8'h20 : (i < 6) ? 8'h60 : 8'h10 + i[7:1] - 8'h03;
      m = m | (i[0] ? 8'h08 : 8'h00);
      u_host_model.io(1'b1, 8'h5A, m, oe);
      check(mode_q, m);
    end
    u_host_model.io(1'b0, 8'h5A, 8'h00, oe);
    check({7'h00, oe}, 8'h01);
    u_host_model.io(1'b0, 8'h40, 8'h00, oe);
    check({7'h00, oe}, 8'h01);
    u_host_model.io(1'b1, 8'h40, 8'h02, oe);
    step(1);
    check({7'h00, enabled_indicator}, 8'h01);
    check(mode_q, 8'h1F);
    u_host_model.io(1'b1, 8'h40, 8'h01, oe);
    step(1);
    check({7'h00, enabled_indicator}, 8'h00);
    u_host_model.mem(1'b0, 16'hC000, 8'h00, q, oe, w);
    check({w[6:0], oe}, 8'h01);
    bank_override_switch = 1'b1;
    u_host_model.mem(1'b1, 16'hC000, 8'h5C, q, oe, w);
    check(w[7:0], 8'h01);
    bank_override_switch = 1'b0;
    u_host_model.io(1'b1, 8'h40, 8'h10, oe);
    u_host_model.mem(1'b1, 16'hD7FF, 8'h3A, q, oe, w);
    u_host_model.mem(1'b0, 16'hC000, 8'h00, q, oe, w);
    check(q, 8'h5C);
    check({w[6:0], oe}, 8'h02);
    u_host_model.mem(1'b0, 16'hD7FF, 8'h00, q, oe, w);
    check(q, 8'h3A);
    u_host_model.mem(1'b1, 16'hD800, 8'h00, q, oe, w);
    check(w[7:0], 8'h00);
    u_host_model.mem(1'b0, 16'hA000, 8'h00, q, oe, w);
    check({w[6:0], oe}, 8'h01);
    video_addr = 13'h17FF;
    step(2);
    check(video_data, 8'h3A);
    wait_jumper = 1'b1;
    u_host_model.mem(1'b0, 16'hC000, 8'h00, q, oe, w);
    check(w[7:0], 8'h02);
    wait_jumper = 1'b0;
    {field_sync, row_start_pulse} = 2'b11;
    fork
      u_host_model.mem(1'b0, 16'hC000, 8'h00, q, oe, w);
      begin
        step(6);
        field_sync = 1'b0;
      end
    join
    check(w[7:0], 8'h06);
    check(q, 8'h5C);
    {field_sync, row_start_pulse} = 2'b10;
    u_host_model.mem(1'b0, 16'hC000, 8'h00, q, oe, w);
    check(w[7:0], 8'h01);
    field_sync = 1'b0;
    protect_jumper = 1'b1;
    u_host_model.io(1'b1, 8'h5A, 8'h00, oe);
    u_host_model.mem(1'b0, 16'hC000, 8'h00, q, oe, w);
    check(w[7:0], 8'h00);
    u_host_model.io(1'b1, 8'h5A, 8'h80, oe);
    u_host_model.mem(1'b0, 16'hC000, 8'h00, q, oe, w);
    check(w[7:0], 8'h01);
    protect_jumper = 1'b0;
    u_host_model.io(1'b1, 8'h40, 8'h02, oe);
    preset = 1'b1;
    step(2);
    preset = 1'b0;
    check({7'h00, enabled_indicator}, 8'h01);
    for (i = 0; i < 3; i++) begin
      u_host_model.io(1'b1, 8'h40, 8'h02, oe);
      {bus_preset_clear_jumper, external_clear_jumper} = i[1:0];
      {preset, external_clear, power_on_clear} = 3'h1 << i;
      step(1);
      {preset, external_clear, power_on_clear} = 3'h0;
      step(1);
      check({7'h00, enabled_indicator}, 8'h00);
    end
    results();
  end
endmodule
